//--- core/adp_top.sv
`timescale 1ns/100ps
module adp_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [1:0]  ata_cs_n,
  output logic      [2:0]  ata_da,
  output logic             ata_dior,
  output logic             ata_diow,
  input  wire logic        ata_iordy,
  input  wire logic [15:0] ata_data_i,
  output logic      [15:0] ata_data_o,
  output logic      [1:0]  ata_data_oe_n,
  output logic             gd_dreq,
  input  wire logic        gd_dack,
  input  wire logic        gd_dior,
  input  wire logic        gd_diow,
  input  wire logic [15:0] gd_data_i,
  output logic      [15:0] gd_data_o,
  output logic             gd_data_oe_n,
  input  wire logic [15:0] dma_rdata,
  output logic             dma_rd_take,
  output logic      [15:0] dma_wdata,
  output logic             dma_wr_valid,
  input  wire logic        fifo_full
);

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] cmd_r;
  logic [15:0] pio_rdata_r;
  logic        pio_waited_r;
  logic [15:0] dma_cnt_r;
  logic        dreq_lvl_r;
  logic        wr_acc;
  logic        hit;
  logic [31:0] rd_mux;
  adp_pkg::adp_pio_e pio_st_r;
  adp_pkg::adp_pio_e pio_st_nxt;

  assign wr_acc = psel && penable && pready && pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      adp_pkg::OFF_CTRL:     rd_mux = ctrl_r;
      adp_pkg::OFF_PIO_CMD:  rd_mux = cmd_r;
      adp_pkg::OFF_PIO_STAT: rd_mux = {pio_rdata_r, 14'h0000, pio_waited_r,
                                       pio_st_r != adp_pkg::PIO_IDLE};
      adp_pkg::OFF_DMA_CNT:  rd_mux = {16'h0000, dma_cnt_r};
      adp_pkg::OFF_DMA_STAT: rd_mux = {30'h0000_0000, dreq_lvl_r, dma_cnt_r != 16'h0000};
      default:               hit = 1'b0;
    endcase
  end

  // Zero-wait slave: pready rises in the access cycle right after setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel && !penable && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= adp_pkg::CTRL_RESET;
    end else if (wr_acc && paddr == adp_pkg::OFF_CTRL) begin
      ctrl_r <= pwdata;
    end
  end

  logic       start_pio;
  logic [2:0] mode;
  logic       rd_pol;
  logic       wr_pol;
  assign start_pio = wr_acc && paddr == adp_pkg::OFF_PIO_CMD && pio_st_r == adp_pkg::PIO_IDLE;
  assign mode      = (ctrl_r[adp_pkg::CTRL_MODE_LSB +: 3] > 3'h4) ? 3'h4
                     : ctrl_r[adp_pkg::CTRL_MODE_LSB +: 3];
  assign rd_pol    = ctrl_r[adp_pkg::CTRL_RDPOL];
  assign wr_pol    = ctrl_r[adp_pkg::CTRL_WRPOL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 32'h0000_0000;
    end else if (start_pio) begin
      cmd_r <= pwdata;
    end
  end

  // ---------------------------------------------------------------------------
  // PIO host cycle
  // ---------------------------------------------------------------------------
  logic [31:0] cmd_cur;
  logic        is_write;
  logic        wide;
  logic [7:0] code;
  logic [2:0] da;
  logic [7:0] tsu1_c;
  logic [7:0] tw1_c;
  logic [7:0] tw2_c;
  logic [7:0] tcy_c;
  logic [7:0] cyc_r;
  logic       tick_load;
  logic [7:0] tick_val;
  logic       tick_done;
  logic       strobe_nxt;
  logic       take_rd;

  // The command being accepted is used at once, so address and selects are right from setup.
  assign cmd_cur  = start_pio ? pwdata : cmd_r;
  assign is_write = cmd_cur[adp_pkg::CMD_WRITE];
  assign code     = cmd_cur[adp_pkg::CMD_CODE_LSB +: 8];
  assign da       = cmd_cur[adp_pkg::CMD_DA_LSB +: 3];
  assign wide     = code == adp_pkg::CODE_PIO_RD || code == adp_pkg::CODE_PIO_WR
                    || (cmd_cur[adp_pkg::CMD_CS0] && !cmd_cur[adp_pkg::CMD_CS1]
                        && da == adp_pkg::DA_DATA_REG);

  always_comb begin
    tsu1_c = 8'h01;
    tw1_c  = 8'h01;
    tw2_c  = 8'h01;
    tcy_c  = 8'h01;
    for (int m = 0; m < adp_pkg::NUM_MODES; m++) begin
      if (mode == m[2:0]) begin
        tsu1_c = adp_pkg::adp_cyc(adp_pkg::TSU1_NS[m]);
        tw1_c  = adp_pkg::adp_cyc(adp_pkg::TW1_NS[m]);
        tw2_c  = adp_pkg::adp_cyc(adp_pkg::TW2_NS[m]);
        tcy_c  = adp_pkg::adp_cyc(adp_pkg::TCY_NS[m]);
      end
    end
  end

  always_comb begin
    pio_st_nxt = pio_st_r;
    tick_load  = 1'b0;
    tick_val   = 8'h00;
    take_rd    = 1'b0;
    unique case (pio_st_r)
      adp_pkg::PIO_IDLE: begin
        if (start_pio) begin
          pio_st_nxt = adp_pkg::PIO_SETUP;
          tick_load  = 1'b1;
          tick_val   = tsu1_c;
        end
      end
      adp_pkg::PIO_SETUP: begin
        if (tick_done) begin
          pio_st_nxt = adp_pkg::PIO_ACTIVE;
        end
      end
      adp_pkg::PIO_ACTIVE: begin
        if (cyc_r == adp_pkg::TSU4_CYC - 8'h01 && !ata_iordy) begin
          pio_st_nxt = adp_pkg::PIO_WAIT;
        end else if (cyc_r + 8'h01 >= tw1_c && cyc_r + 8'h01 >= adp_pkg::TSU4_CYC) begin
          pio_st_nxt = adp_pkg::PIO_RECOV;
          take_rd    = 1'b1;
          tick_load  = 1'b1;
          tick_val   = tw2_c;
        end
      end
      adp_pkg::PIO_WAIT: begin
        if (ata_iordy && cyc_r + 8'h01 >= tw1_c) begin
          pio_st_nxt = adp_pkg::PIO_RECOV;
          take_rd    = 1'b1;
          tick_load  = 1'b1;
          tick_val   = tw2_c;
        end
      end
      adp_pkg::PIO_RECOV: begin
        if (tick_done && cyc_r + 8'h01 >= tcy_c) begin
          pio_st_nxt = adp_pkg::PIO_IDLE;
        end
      end
      default: pio_st_nxt = adp_pkg::PIO_IDLE;
    endcase
  end

  adp_tick u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tick_load),
    .load_val (tick_val),
    .done     (tick_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pio_st_r <= adp_pkg::PIO_IDLE;
    end else begin
      pio_st_r <= pio_st_nxt;
    end
  end

  // Cycle counter runs from strobe assertion so the full cycle time covers waits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 8'h00;
    end else if (pio_st_r == adp_pkg::PIO_SETUP || pio_st_r == adp_pkg::PIO_IDLE) begin
      cyc_r <= 8'h00;
    end else if (cyc_r != 8'hff) begin
      cyc_r <= cyc_r + 8'h01;
    end
  end

  assign strobe_nxt = pio_st_nxt == adp_pkg::PIO_ACTIVE || pio_st_nxt == adp_pkg::PIO_WAIT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ata_cs_n      <= 2'h3;
      ata_da        <= 3'h0;
      ata_dior      <= 1'b1;
      ata_diow      <= 1'b1;
      ata_data_o    <= 16'h0000;
      ata_data_oe_n <= 2'h3;
    end else begin
      ata_dior <= (strobe_nxt && !is_write) ? rd_pol : !rd_pol;
      ata_diow <= (strobe_nxt && is_write) ? wr_pol : !wr_pol;
      if (pio_st_nxt != adp_pkg::PIO_IDLE) begin
        ata_cs_n <= ~{cmd_cur[adp_pkg::CMD_CS1], cmd_cur[adp_pkg::CMD_CS0]};
        ata_da   <= da;
      end else begin
        ata_cs_n <= 2'h3;
      end
      ata_data_o <= cmd_cur[adp_pkg::CMD_DATA_LSB +: 16];
      // The bus is driven only in write cycles, so a read never contends with
      // the drive releasing it.
      if (pio_st_nxt != adp_pkg::PIO_IDLE && is_write) begin
        ata_data_oe_n <= {!wide, 1'b0};
      end else begin
        ata_data_oe_n <= 2'h3;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pio_rdata_r  <= 16'h0000;
      pio_waited_r <= 1'b0;
    end else begin
      if (take_rd && !is_write) begin
        pio_rdata_r <= wide ? ata_data_i : {8'h00, ata_data_i[7:0]};
      end
      if (start_pio) begin
        pio_waited_r <= 1'b0;
      end else if (pio_st_r == adp_pkg::PIO_WAIT) begin
        pio_waited_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Generic DMA slave port
  // ---------------------------------------------------------------------------
  logic [1:0]  dmode;
  logic [7:0]  burst;
  logic        dir_rd;
  logic        dack_act;
  logic        stb;
  logic        stb_q;
  logic        stb_on;
  logic        stb_off;
  logic        last_grp;
  logic        hold_r;
  logic [7:0]  grp_r;
  logic [15:0] gd_in_q;
  logic        lvl;

  assign dmode    = ctrl_r[adp_pkg::CTRL_DMODE_LSB +: 2];
  assign burst    = ctrl_r[adp_pkg::CTRL_BURST_LSB +: 8];
  assign dir_rd   = ctrl_r[adp_pkg::CTRL_DIR];
  assign dack_act = gd_dack == ctrl_r[adp_pkg::CTRL_ACKPOL];
  assign stb      = (dmode == adp_pkg::DMODE_ACK) ? dack_act
                    : dack_act && (dir_rd ? gd_dior == rd_pol : gd_diow == wr_pol);
  assign stb_on   = stb && !stb_q && dma_cnt_r != 16'h0000;
  assign stb_off  = !stb && stb_q && dma_cnt_r != 16'h0000;
  assign last_grp = dma_cnt_r == 16'h0001
                    || (burst == adp_pkg::BURST_SINGLE)
                    || (burst != adp_pkg::BURST_CONT && grp_r + 8'h01 >= burst);
  assign lvl      = dma_cnt_r != 16'h0000 && !fifo_full && !hold_r
                    && !(stb_on && last_grp);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_q   <= 1'b0;
      gd_in_q <= 16'h0000;
    end else begin
      stb_q   <= stb;
      gd_in_q <= gd_data_i;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_cnt_r <= 16'h0000;
    end else if (wr_acc && paddr == adp_pkg::OFF_DMA_CNT) begin
      dma_cnt_r <= pwdata[15:0];
    end else if (stb_off) begin
      dma_cnt_r <= dma_cnt_r - 16'h0001;
    end
  end

  // The request drops at the strobe that ends a group and returns after it ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 1'b0;
      grp_r  <= 8'h00;
    end else if (wr_acc && paddr == adp_pkg::OFF_DMA_CNT) begin
      hold_r <= 1'b0;
      grp_r  <= 8'h00;
    end else if (stb_on) begin
      hold_r <= last_grp;
      grp_r  <= last_grp ? 8'h00 : grp_r + 8'h01;
    end else if (stb_off) begin
      hold_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq_lvl_r   <= 1'b0;
      gd_dreq      <= 1'b0;
      gd_data_o    <= 16'h0000;
      gd_data_oe_n <= 1'b1;
      dma_rd_take  <= 1'b0;
      dma_wdata    <= 16'h0000;
      dma_wr_valid <= 1'b0;
    end else begin
      dreq_lvl_r   <= lvl;
      gd_dreq      <= lvl == ctrl_r[adp_pkg::CTRL_REQPOL];
      gd_data_o    <= dma_rdata;
      gd_data_oe_n <= !(dir_rd && dack_act && dma_cnt_r != 16'h0000);
      dma_rd_take  <= stb_off && dir_rd;
      dma_wr_valid <= stb_off && !dir_rd;
      if (stb_off && !dir_rd) begin
        dma_wdata <= gd_in_q;
      end
    end
  end

endmodule

//--- core/adp_pkg.sv
// Operation
// - PIO drive address is the two chip selects plus three address lines.
// - Task-file accesses use data bits 7..0; the data register uses all 16.
// - PIO transfers issued by command codes 04h and 05h use 16 data bits.
// - IORDY is sampled at least 35 ns after the strobe is asserted.
// - A released (high) IORDY adds no wait state.
// - IORDY high again by the sampling point adds no wait state.
// - IORDY low past the sampling point stretches the strobe until IORDY returns.
// - Each PIO cycle lasts at least 600, 383, 240, 180 or 120 ns per mode.
// - Recovery phase is lengthened until the full cycle minimum holds.
// - Read and write strobes each have programmable active polarity.
// - Burst 00h keeps the request up until the last transfer or FIFO full.
// - Burst 01h raises one request per transfer.
// - Burst above 01h raises one request per group of N transfers.
package adp_pkg;

  localparam int CLK_MHZ = 40;
  localparam int NS_PER_US = 1000;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_PIO_CMD  = 12'h004;
  localparam logic [11:0] OFF_PIO_STAT = 12'h008;
  localparam logic [11:0] OFF_DMA_CNT  = 12'h00c;
  localparam logic [11:0] OFF_DMA_STAT = 12'h010;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_RDPOL     = 3;
  localparam int CTRL_WRPOL     = 4;
  localparam int CTRL_ACKPOL    = 5;
  localparam int CTRL_REQPOL    = 6;
  localparam int CTRL_DIR       = 7;
  localparam int CTRL_DMODE_LSB = 8;
  localparam int CTRL_BURST_LSB = 16;

  localparam int CMD_DA_LSB   = 0;
  localparam int CMD_CS0      = 3;
  localparam int CMD_CS1      = 4;
  localparam int CMD_WRITE    = 5;
  localparam int CMD_CODE_LSB = 8;
  localparam int CMD_DATA_LSB = 16;

  localparam logic [7:0] CODE_PIO_RD = 8'h04;
  localparam logic [7:0] CODE_PIO_WR = 8'h05;
  localparam logic [2:0] DA_DATA_REG = 3'h0;

  localparam logic [1:0] DMODE_STROBES = 2'h0;
  localparam logic [1:0] DMODE_ACK     = 2'h2;
  localparam logic [7:0] BURST_CONT    = 8'h00;
  localparam logic [7:0] BURST_SINGLE  = 8'h01;

  // ---------------------------------------------------------------------------
  // PIO timing per mode 0..4
  // ---------------------------------------------------------------------------
  localparam int NUM_MODES = 5;
  typedef int adp_ns_t [NUM_MODES];
  localparam adp_ns_t TCY_NS = '{600, 383, 240, 180, 120};
  localparam adp_ns_t TSU1_NS = '{70, 50, 30, 30, 25};
  localparam adp_ns_t TW1_NS = '{165, 125, 100, 80, 70};
  localparam adp_ns_t TW2_NS = '{0, 0, 0, 70, 25};
  localparam int TSU4_NS = 35;
  localparam int TW3_MAX_NS = 1250;

  function automatic logic [7:0] adp_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction

  localparam logic [7:0] TSU4_CYC = adp_cyc(TSU4_NS);

  typedef enum logic [2:0] {
    PIO_IDLE   = 3'b000,
    PIO_SETUP  = 3'b001,
    PIO_ACTIVE = 3'b010,
    PIO_WAIT   = 3'b011,
    PIO_RECOV  = 3'b100
  } adp_pio_e;

endpackage

//--- core/adp_tick.sv
`timescale 1ns/100ps
module adp_tick (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  output logic            done
);

  logic [7:0] cnt_r;

  // Counts down once per clock from load_val to zero; done marks the last cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  assign done = (cnt_r <= 8'h01);

endmodule

//--- tb/adp_chk.sv
`timescale 1ns/100ps
module adp_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [1:0] ata_cs_n,
  input wire logic [2:0] ata_da,
  input wire logic       ata_dior,
  input wire logic       ata_diow,
  input wire logic       ata_iordy,
  input wire logic [1:0] ata_data_oe_n,
  input wire logic       gd_dreq,
  input wire logic       fifo_full,
  input wire logic       dma_rd_take,
  input wire logic       dma_wr_valid
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire act = ata_cs_n != 2'b11;
  sequence s_rd_held;
    $stable(ata_dior)[*2];
  endsequence
  sequence s_wr_held;
    $stable(ata_diow)[*2];
  endsequence
  a_cs_edge_quiet: assert property (
    $changed(ata_cs_n) |-> $stable(ata_dior) && $stable(ata_diow))
    else $error("strobe moved with chip select");
  a_rd_width: assert property (
    act && $changed(ata_dior) |=> s_rd_held)
    else $error("read strobe phase too short");
  a_wr_width: assert property (
    act && $changed(ata_diow) |=> s_wr_held)
    else $error("write strobe phase too short");
  a_addr_steady: assert property (
    act && $past(act) |-> $stable(ata_da))
    else $error("drive address moved in a cycle");
  a_wait_strobe: assert property (
    act && ($changed(ata_dior) || $changed(ata_diow)) |-> $past(ata_iordy))
    else $error("strobe moved while ready low");
  a_oe_lane: assert property (
    !ata_data_oe_n[1] |-> !ata_data_oe_n[0] && act)
    else $error("upper lane driven alone");
  a_full_quiet: assert property (
    fifo_full && $past(fifo_full) && $past(fifo_full, 2) |-> $stable(gd_dreq))
    else $error("request moved while full");
  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  a_word_pulse: assert property (
    dma_wr_valid || dma_rd_take |=> !dma_wr_valid && !dma_rd_take)
    else $error("word pulse longer than one cycle");
endmodule

bind adp_top adp_chk i_chk (
  .pclk, .presetn, .psel, .penable, .pready, .ata_cs_n, .ata_da, .ata_dior, .ata_diow,
  .ata_iordy, .ata_data_oe_n, .gd_dreq, .fifo_full, .dma_rd_take, .dma_wr_valid
);

//--- tb/adp_drv_model.sv
`timescale 1ns/100ps
module adp_drv_model (
  input  wire logic        pclk,
  input  wire logic [1:0]  cs_n,
  input  wire logic        dior,
  input  wire logic        diow,
  input  wire logic        rd_hi,
  input  wire logic        wr_hi,
  input  wire logic [5:0]  wait_cyc,
  input  wire logic [15:0] wdat,
  input  wire logic [1:0]  oe_n,
  output logic             iordy,
  output logic      [15:0] rdat,
  output logic      [15:0] wr_seen
);
  localparam logic [15:0] RD_VAL = 16'hbeef;
  logic       on;
  logic       was_on;
  logic [5:0] cnt;
  assign on = cs_n != 2'b11 && (dior == rd_hi || diow == wr_hi);
  // Data is valid for the whole strobe; released lines show the inverse.
  assign rdat = (on && dior == rd_hi) ? RD_VAL : ~RD_VAL;
  initial begin
    iordy = 1'b1;
    was_on = 1'b0;
    cnt = '0;
  end
  // Ready moves between clock edges, as a real drive would.
  always @(negedge pclk) begin
    was_on <= on;
    if (on && !was_on && wait_cyc != 0) begin
      iordy <= 1'b0;
      cnt <= wait_cyc;
    end else if (cnt > 6'd1) begin
      cnt <= cnt - 6'd1;
    end else if (cnt == 6'd1) begin
      iordy <= 1'b1;
      cnt <= '0;
    end
    if (on && diow == wr_hi) begin
      wr_seen <= {oe_n[1] ? 8'h00 : wdat[15:8], oe_n[0] ? 8'h00 : wdat[7:0]};
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re, dr;
  logic        ata_dior, ata_diow, ata_iordy, gd_dreq, gd_dack, gd_dior, gd_diow;
  logic        dma_rd_take, dma_wr_valid, fifo_full, rd_hi, wr_hi, gd_data_oe_n;
  logic [1:0]  ata_cs_n, ata_data_oe_n;
  logic [2:0]  ata_da;
  logic [5:0]  wait_cyc;
  logic [11:0] paddr;
  logic [15:0] ata_data_i, ata_data_o, gd_data_i, gd_data_o, dma_rdata, dma_wdata;
  logic [15:0] wr_seen, last_w;
  logic [31:0] pwdata, prdata, rv;
  int          n_errors, checked, cs_cnt, cs_len, n_word, n0, mn;

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  adp_top i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ata_cs_n, .ata_da, .ata_dior, .ata_diow, .ata_iordy, .ata_data_i, .ata_data_o,
    .ata_data_oe_n, .gd_dreq, .gd_dack, .gd_dior, .gd_diow, .gd_data_i, .gd_data_o,
    .gd_data_oe_n, .dma_rdata, .dma_rd_take, .dma_wdata, .dma_wr_valid, .fifo_full
  );
  adp_drv_model i_drive (
    .pclk, .cs_n(ata_cs_n), .dior(ata_dior), .diow(ata_diow), .rd_hi, .wr_hi, .wait_cyc,
    .wdat(ata_data_o), .oe_n(ata_data_oe_n), .iordy(ata_iordy), .rdat(ata_data_i), .wr_seen
  );

  // Measures how long chip select stays active and counts moved words.
  always @(posedge pclk) begin
    if (ata_cs_n !== 2'b11) begin
      cs_cnt <= cs_cnt + 1;
    end else if (cs_cnt != 0) begin
      cs_len <= cs_cnt;
      cs_cnt <= 0;
    end
    if (dma_wr_valid || dma_rd_take) begin
      n_word <= n_word + 1;
    end
    if (dma_wr_valid) begin
      last_w <= dma_wdata;
    end
  end

  function automatic int cyc(input int ns);
    return (ns * 40 + 999) / 1000;
  endfunction

  function automatic logic [31:0] cmd(input logic [15:0] wd, input logic [7:0] code,
                                      input logic wr, input logic [2:0] da);
    return {wd, code, 2'b00, wr, 2'b01, da};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pio(input logic [31:0] c);
    apb(1'b1, adp_pkg::OFF_PIO_CMD, c);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, adp_pkg::OFF_PIO_STAT, '0);
      if (rv[0] === 1'b0) break;
    end
    chk(16'(rv[0]), 16'h0, "pio cycle ended");
  endtask

  task automatic xfer(input logic ack_only, input logic rd, input logic [15:0] d,
                      input logic exp);
    gd_dack <= 1'b1;
    gd_dior <= !ack_only && rd;
    gd_diow <= !ack_only && !rd;
    gd_data_i <= d;
    repeat (3) @(posedge pclk);
    chk(16'(gd_dreq), 16'(exp), "request during transfer");
    chk(16'(gd_data_oe_n), 16'(!rd), "data drive enable");
    @(posedge pclk);
    gd_dack <= 1'b0;
    gd_dior <= 1'b0;
    gd_diow <= 1'b0;
    @(posedge pclk);
    gd_data_i <= ~d;
    repeat (2) @(posedge pclk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    gd_dack = 1'b0;
    gd_dior = 1'b0;
    gd_diow = 1'b0;
    gd_data_i = '0;
    dma_rdata = 16'h5a5a;
    fifo_full = 1'b0;
    rd_hi = 1'b0;
    wr_hi = 1'b0;
    wait_cyc = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, adp_pkg::OFF_CTRL, '0);
    chk(rv[15:0], adp_pkg::CTRL_RESET[15:0], "control reset");
    apb(1'b0, 12'h014, '0);
    chk(16'({re, rv != 0}), 16'h2, "unmapped read");
    apb(1'b1, adp_pkg::OFF_PIO_STAT, 32'h3);
    apb(1'b0, adp_pkg::OFF_PIO_STAT, '0);
    chk(16'(rv[1:0]), 16'h0, "status read only");
    $display("register test done");
    for (int m = 0; m < 5; m++) begin
      rd_hi <= (m == 3);
      wait_cyc <= (m == 0) ? 6'd20 : 6'(m == 1);
      apb(1'b1, adp_pkg::OFF_CTRL, (m == 3) ? 32'h0b : 32'(m));
      pio(cmd(16'h0, adp_pkg::CODE_PIO_RD, 1'b0, adp_pkg::DA_DATA_REG));
      mn = cyc(adp_pkg::TSU1_NS[m]) + cyc(adp_pkg::TCY_NS[m]);
      chk(rv[31:16], 16'hbeef, "wide read");
      chk(16'(rv[1]), 16'(m == 0), "wait flag");
      chk(16'(cs_len >= mn), 16'h1, "cycle time");
    end
    pio(cmd(16'h0, 8'h00, 1'b0, 3'h7));
    chk(rv[31:16], 16'h00ef, "narrow read");
    chk(16'(ata_da), 16'h0007, "drive address");
    wr_hi <= 1'b1;
    apb(1'b1, adp_pkg::OFF_CTRL, 32'h14);
    pio(cmd(16'h1234, adp_pkg::CODE_PIO_WR, 1'b1, adp_pkg::DA_DATA_REG));
    chk(wr_seen, 16'h1234, "wide write");
    pio(cmd(16'ha5c3, 8'h00, 1'b1, 3'h2));
    chk(wr_seen, 16'h00c3, "narrow write");
    $display("pio test done");
    rd_hi <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      dr = (k == 1);
      apb(1'b1, adp_pkg::OFF_CTRL, {8'h0, 8'(k), 6'h0, (k == 1) ? 2'h2 : 2'h0, dr, 7'h7c});
      n0 = n_word;
      apb(1'b1, adp_pkg::OFF_DMA_CNT, 32'h4);
      repeat (2) @(posedge pclk);
      if (k == 0) begin
        fifo_full <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(16'(gd_dreq), 16'h0, "full drops request");
        fifo_full <= 1'b0;
        repeat (2) @(posedge pclk);
      end
      for (int i = 0; i < 4; i++) begin
        chk(16'(gd_dreq), 16'h1, "request raised");
        xfer(k == 1, dr, 16'hc000 + 16'(i),
             (k == 0 && i != 3) || (k == 2 && i[0] == 1'b0));
      end
      chk(16'(gd_dreq), 16'h0, "request after count");
      chk(16'(n_word - n0), 16'h4, "words moved");
      chk(dr ? gd_data_o : last_w, dr ? 16'h5a5a : 16'hc003, "word data");
    end
    $display("dma test done");
    test_done();
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #500000;
    n_errors++;
    test_done();
  end
endmodule
